// *** inc/trig_params.svh ***
/*
 Constants of the sweep trigger controller: register offsets, field
 positions, widths and reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
// Behaviour
// - Triggers are accepted only while no sweep is running.
// - Three sources: internal, manual, external; one source serves every channel.
// - Internal source retriggers at once after each measurement completes.
// - Manual source fires once per manual-trigger request.
// - External input qualified by high, low, rising or falling, once ready.
// - A level lasting over one sweep retriggers after every completed sweep.
// - Software selects which external input carries the trigger.
// - An accepted external trigger waits a programmable delay before sweeping.
// - Scope all: each trigger goes to every channel not held.
// - Scope channel: trigger goes to next non-held channel, advancing in order.
// - After reset the source is internal and the scope is all.
// - A continuous channel takes unlimited triggers, one sweep each.
// - A counted channel takes its programmed number of triggers, then holds.
// - A single channel takes one trigger, sweeps once, then holds.
// - A held channel ignores triggers and never sweeps.
// - Point step allowed only with manual or external source and channel scope.
// - Point step measures one point per trigger; after the sweep's last point, passes to next channel.
// - Forward measurements precede reverse ones, unless interleaved or point step.
// - Trigger output with enable, polarity, position and pulse width.
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
`define NCH 4
`define CHW 2
`define NIN 4
`define INSEL_W 2
`define DW 32
`define AW 5
`define A_CTRL 5'h00
`define A_DELAY 5'h04
`define A_OUTW 5'h08
`define A_CHST 5'h0C
`define A_CHCNT 5'h10
`define A_STAT 5'h14
`define A_LEFT 5'h18
`define F_SRC 1:0
`define F_SCOPE 2
`define F_PSTEP 3
`define F_QUAL 5:4
`define F_INSEL 7:6
`define F_ALT 8
`define F_OEN 9
`define F_OPOL 10
`define F_OPOS 12:11
`define F_MAN 13
`define F_S_PTR 5:4
`define F_S_FSM 10:8
`define CHM_W 2
`define DLY_W 16
`define OW_W 8
`define CNT_W 8
`define RST_OUTW 8'h01
`define RST_TOUT 1'b1
`endif

// *** inc/trig_pkg.sv ***
/*
 Types of the sweep trigger controller: modes, states and carriers.
 Assumes the constants header sits beside it.
*/
`default_nettype none
`include "trig_params.svh"
package trig_pkg;
    typedef enum logic [1:0] {SRC_INT, SRC_MAN, SRC_EXT} src_t;
    typedef enum logic {SCOPE_ALL, SCOPE_CHAN} scope_t;
    typedef enum logic [1:0] {QUAL_HIGH, QUAL_LOW, QUAL_RISE, QUAL_FALL} qual_t;
    typedef enum logic [1:0] {CH_CONT, CH_COUNTED, CH_SINGLE, CH_HOLD} chmode_t;
    typedef enum logic [1:0] {OPOS_START, OPOS_END, OPOS_POINT} opos_t;
    typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_FWD, ST_REV, ST_STEP} fsm_t;
    typedef struct packed {
        src_t src;
        scope_t scope;
        logic pstep;
        qual_t qual;
        logic [`INSEL_W-1:0] insel;
        logic alt;
        logic oen;
        logic opol;
        opos_t opos;
    } cfg_t;
    typedef struct packed {
        logic start;
        logic step;
        logic reverse;
        logic interleave;
        logic [`NCH-1:0] mask;
    } sweep_cmd_t;
    typedef struct packed {
        logic point_done;
        logic sweep_done;
    } sweep_stat_t;
    typedef struct packed {
        logic [`AW-1:0] addr;
        logic [`DW-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic [`NIN-1:0] meta;
        logic [`NIN-1:0] sync;
        logic prev;
        logic hit;
    } qual_state_t;
    typedef struct packed {
        cfg_t cfg;
        logic [`DLY_W-1:0] dly;
        logic [`OW_W-1:0] ow;
        chmode_t [`NCH-1:0] chm;
        logic [`NCH-1:0][`CNT_W-1:0] cnt_prog;
        logic [`NCH-1:0][`CNT_W-1:0] cnt_left;
        fsm_t fsm;
        logic [`CHW-1:0] ptr;
        logic [`DLY_W-1:0] dcnt;
        logic [`OW_W-1:0] ocnt;
        sweep_cmd_t cmd;
        logic tout;
        logic [`DW-1:0] rdata;
    } ctl_state_t;
endpackage
`default_nettype wire

// *** logic/ext_trig_qual.sv ***
/*
 External trigger qualifier: synchronises the trigger pins, picks one and
 flags a level match while it lasts or an edge match for one cycle.
 Assumes asynchronous pins and select and mode from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module ext_trig_qual (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [`NIN-1:0] pin_i,
    input wire logic [`INSEL_W-1:0] sel_i,
    input wire trig_pkg::qual_t qual_i,
    output logic hit_o
);
    trig_pkg::qual_state_t s;
    trig_pkg::qual_state_t next_s;

    // A change of selected input may look like one edge; software should
    // select the input before arming edge mode.
    always_comb begin
        next_s = s;
        next_s.meta = pin_i;
        next_s.sync = s.meta;
        next_s.prev = s.sync[sel_i];
        unique case (qual_i)
            trig_pkg::QUAL_HIGH: next_s.hit = s.sync[sel_i];
            trig_pkg::QUAL_LOW: next_s.hit = !s.sync[sel_i];
            trig_pkg::QUAL_RISE: next_s.hit = s.sync[sel_i] && !s.prev;
            trig_pkg::QUAL_FALL: next_s.hit = !s.sync[sel_i] && s.prev;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign hit_o = s.hit;
endmodule
`default_nettype wire

// *** logic/sweep_trigger_controller.sv ***
/*
 Sweep trigger controller: source choice, channel scope, per-channel
 trigger state, point stepping, external delay and trigger output.
 Assumes one 50 MHz clock, a sweep engine on that clock which pulses
 point and sweep completion, and software on a plain strobe port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module sweep_trigger_controller (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire trig_pkg::reg_req_t req_i,
    output logic [`DW-1:0] rdata_o,
    input wire logic [`NIN-1:0] ext_trig_i,
    input wire trig_pkg::sweep_stat_t eng_i,
    output trig_pkg::sweep_cmd_t cmd_o,
    output logic trig_out_o
);
    trig_pkg::ctl_state_t s;
    trig_pkg::ctl_state_t next_s;
    logic ext_hit;
    logic [`NCH-1:0] held;
    logic [`CHW-1:0] tgt;
    logic man_wr;
    logic fire;
    logic accept;
    logic go;
    logic complete;
    logic ev;
    logic [`DW-1:0] w;

    function automatic logic [`NCH-1:0] held_of(input trig_pkg::chmode_t [`NCH-1:0] m);
        logic [`NCH-1:0] h;
        h = '0;
        for (int i = 0; i < `NCH; i++) begin
            h[i] = (m[i] == trig_pkg::CH_HOLD);
        end
        return h;
    endfunction

    // First channel at or after p that is not held, in ascending order
    function automatic logic [`CHW-1:0] next_ch(input logic [`CHW-1:0] p,
                                                input logic [`NCH-1:0] h);
        logic [`CHW-1:0] r;
        logic found;
        r = p;
        found = 1'b0;
        for (int k = 0; k < `NCH; k++) begin
            logic [`CHW-1:0] c;
            c = p + `CHW'(k);
            if (!found && !h[c]) begin
                r = c;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    ext_trig_qual u_qual (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(ext_trig_i),
        .sel_i(s.cfg.insel),
        .qual_i(s.cfg.qual),
        .hit_o(ext_hit)
    );

    always_comb begin
        next_s = s;
        w = '0;
        go = 1'b0;
        complete = 1'b0;
        ev = 1'b0;
        next_s.cmd.start = 1'b0;
        next_s.cmd.step = 1'b0;
        held = held_of(s.chm);
        tgt = next_ch(s.ptr, held);
        man_wr = req_i.wr && (req_i.addr == `A_CTRL) && req_i.wdata[`F_MAN];
        // One global source for all channels; the unused code acts as internal
        unique case (s.cfg.src)
            trig_pkg::SRC_INT: fire = 1'b1;
            trig_pkg::SRC_MAN: fire = man_wr;
            trig_pkg::SRC_EXT: fire = ext_hit;
            default: fire = 1'b1;
        endcase
        // Requests that arrive while busy are dropped, not queued
        accept = (s.fsm == trig_pkg::ST_IDLE) && fire && !(&held);

        unique case (s.fsm)
            trig_pkg::ST_IDLE: begin
                if (accept) begin
                    if (s.cfg.scope == trig_pkg::SCOPE_ALL) begin
                        next_s.cmd.mask = ~held;
                    end else begin
                        next_s.cmd.mask = '0;
                        next_s.cmd.mask[tgt] = 1'b1;
                    end
                    next_s.ptr = tgt;
                    if (s.cfg.src == trig_pkg::SRC_EXT) begin
                        next_s.fsm = trig_pkg::ST_DELAY;
                        next_s.dcnt = s.dly;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            trig_pkg::ST_DELAY: begin
                if (s.dcnt == '0) begin
                    go = 1'b1;
                end else begin
                    next_s.dcnt = s.dcnt - 1'b1;
                end
            end
            trig_pkg::ST_FWD: begin
                if (eng_i.sweep_done) begin
                    if (s.cmd.interleave) begin
                        complete = 1'b1;
                    end else begin
                        next_s.fsm = trig_pkg::ST_REV;
                        next_s.cmd.start = 1'b1;
                        next_s.cmd.reverse = 1'b1;
                    end
                end
            end
            trig_pkg::ST_REV: begin
                if (eng_i.sweep_done) begin
                    complete = 1'b1;
                end
            end
            trig_pkg::ST_STEP: begin
                if (eng_i.point_done) begin
                    if (eng_i.sweep_done) begin
                        complete = 1'b1;
                    end else begin
                        next_s.fsm = trig_pkg::ST_IDLE;
                    end
                end
            end
            default: next_s.fsm = trig_pkg::ST_IDLE;
        endcase

        if (go) begin
            if (s.cfg.pstep) begin
                next_s.fsm = trig_pkg::ST_STEP;
                next_s.cmd.step = 1'b1;
            end else begin
                next_s.fsm = trig_pkg::ST_FWD;
                next_s.cmd.start = 1'b1;
                next_s.cmd.reverse = 1'b0;
                next_s.cmd.interleave = s.cfg.alt;
            end
        end

        if (complete) begin
            next_s.fsm = trig_pkg::ST_IDLE;
            if (s.cfg.scope == trig_pkg::SCOPE_CHAN) begin
                next_s.ptr = s.ptr + 1'b1;
            end
            // Continuous channels keep their state unchanged
            for (int i = 0; i < `NCH; i++) begin
                if (s.cmd.mask[i] && s.chm[i] == trig_pkg::CH_COUNTED) begin
                    if (s.cnt_left[i] <= `CNT_W'(1)) begin
                        next_s.chm[i] = trig_pkg::CH_HOLD;
                        next_s.cnt_left[i] = '0;
                    end else begin
                        next_s.cnt_left[i] = s.cnt_left[i] - 1'b1;
                    end
                end
                if (s.cmd.mask[i] && s.chm[i] == trig_pkg::CH_SINGLE) begin
                    next_s.chm[i] = trig_pkg::CH_HOLD;
                end
            end
        end

        // Trigger output: one pulse of ow cycles per chosen event
        ev = ((s.cfg.opos == trig_pkg::OPOS_START) && (next_s.cmd.start || next_s.cmd.step))
            || ((s.cfg.opos == trig_pkg::OPOS_END) && complete)
            || ((s.cfg.opos == trig_pkg::OPOS_POINT) && eng_i.point_done
                && s.fsm != trig_pkg::ST_IDLE && s.fsm != trig_pkg::ST_DELAY);
        if (ev) begin
            next_s.ocnt = s.ow;
        end else if (s.ocnt != '0) begin
            next_s.ocnt = s.ocnt - 1'b1;
        end
        next_s.tout = (s.cfg.oen && next_s.ocnt != '0) ? s.cfg.opol : !s.cfg.opol;

        // Software writes win over the hardware move to hold in the same cycle
        if (req_i.wr) begin
            unique case (req_i.addr)
                `A_CTRL: begin
                    next_s.cfg.src = trig_pkg::src_t'(req_i.wdata[`F_SRC]);
                    next_s.cfg.scope = trig_pkg::scope_t'(req_i.wdata[`F_SCOPE]);
                    next_s.cfg.qual = trig_pkg::qual_t'(req_i.wdata[`F_QUAL]);
                    next_s.cfg.insel = req_i.wdata[`F_INSEL];
                    next_s.cfg.alt = req_i.wdata[`F_ALT];
                    next_s.cfg.oen = req_i.wdata[`F_OEN];
                    next_s.cfg.opol = req_i.wdata[`F_OPOL];
                    next_s.cfg.opos = trig_pkg::opos_t'(req_i.wdata[`F_OPOS]);
                    next_s.cfg.pstep = req_i.wdata[`F_PSTEP]
                        && (next_s.cfg.src == trig_pkg::SRC_MAN || next_s.cfg.src == trig_pkg::SRC_EXT)
                        && next_s.cfg.scope == trig_pkg::SCOPE_CHAN;
                end
                `A_DELAY: next_s.dly = req_i.wdata[`DLY_W-1:0];
                `A_OUTW: next_s.ow = req_i.wdata[`OW_W-1:0];
                `A_CHST: begin
                    for (int i = 0; i < `NCH; i++) begin
                        next_s.chm[i] = trig_pkg::chmode_t'(req_i.wdata[`CHM_W*i +: `CHM_W]);
                        next_s.cnt_left[i] = s.cnt_prog[i];
                        if (next_s.chm[i] == trig_pkg::CH_COUNTED && s.cnt_prog[i] == '0) begin
                            next_s.chm[i] = trig_pkg::CH_HOLD;
                        end
                    end
                end
                `A_CHCNT: next_s.cnt_prog = req_i.wdata;
                default: ;
            endcase
        end

        if (req_i.rd) begin
            unique case (req_i.addr)
                `A_CTRL: begin
                    w[`F_SRC] = s.cfg.src;
                    w[`F_SCOPE] = s.cfg.scope;
                    w[`F_PSTEP] = s.cfg.pstep;
                    w[`F_QUAL] = s.cfg.qual;
                    w[`F_INSEL] = s.cfg.insel;
                    w[`F_ALT] = s.cfg.alt;
                    w[`F_OEN] = s.cfg.oen;
                    w[`F_OPOL] = s.cfg.opol;
                    w[`F_OPOS] = s.cfg.opos;
                end
                `A_DELAY: w[`DLY_W-1:0] = s.dly;
                `A_OUTW: w[`OW_W-1:0] = s.ow;
                `A_CHST: w[`CHM_W*`NCH-1:0] = s.chm;
                `A_CHCNT: w = s.cnt_prog;
                `A_STAT: begin
                    w[`NCH-1:0] = held;
                    w[`F_S_PTR] = s.ptr;
                    w[`F_S_FSM] = s.fsm;
                end
                `A_LEFT: w = s.cnt_left;
                default: w = '0;
            endcase
        end
        next_s.rdata = w;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
            s.cfg.src <= trig_pkg::SRC_INT;
            s.cfg.scope <= trig_pkg::SCOPE_ALL;
            s.ow <= `RST_OUTW;
            s.tout <= `RST_TOUT;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign cmd_o = s.cmd;
    assign trig_out_o = s.tout;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_busy_ignore:
    assert property ((s.fsm == trig_pkg::ST_FWD) && !eng_i.sweep_done
        |=> !s.cmd.step && s.cmd.mask == $past(s.cmd.mask))
        else $error("trigger taken during a sweep");

    // Sampled reset term keeps out the attempt started on the release edge
    chk_int_retrig:
    assert property (arst_n_i && (s.fsm == trig_pkg::ST_IDLE) && s.cfg.src == trig_pkg::SRC_INT && !(&held)
        |=> s.cmd.start && s.fsm == trig_pkg::ST_FWD)
        else $error("internal source did not retrigger");

    chk_manual_fire:
    assert property ((s.fsm == trig_pkg::ST_IDLE) && s.cfg.src == trig_pkg::SRC_MAN
        && man_wr && !(&held) && req_i.wdata[`F_SRC] == trig_pkg::SRC_MAN
        |=> s.cmd.start || s.cmd.step)
        else $error("manual request did not trigger");

    chk_delay_count:
    assert property ((s.fsm == trig_pkg::ST_DELAY) && s.dcnt != '0
        |=> s.fsm == trig_pkg::ST_DELAY && s.dcnt == $past(s.dcnt) - 1'b1)
        else $error("external delay miscounted");

    chk_delay_end:
    assert property ((s.fsm == trig_pkg::ST_DELAY) && s.dcnt == '0
        |=> s.cmd.start || s.cmd.step)
        else $error("sweep not started after delay");

    chk_all_mask:
    assert property (arst_n_i && accept && s.cfg.scope == trig_pkg::SCOPE_ALL
        |=> s.cmd.mask == ~$past(held))
        else $error("scope all missed a channel");

    chk_chan_one:
    assert property (accept && s.cfg.scope == trig_pkg::SCOPE_CHAN
        |=> $onehot(s.cmd.mask))
        else $error("channel scope hit several channels");

    chk_hold_skip:
    assert property (accept |=> (s.cmd.mask & $past(held)) == '0)
        else $error("held channel was triggered");

    chk_single_hold:
    assert property (complete && s.cmd.mask[2] && s.chm[2] == trig_pkg::CH_SINGLE && !req_i.wr
        |=> s.chm[2] == trig_pkg::CH_HOLD)
        else $error("single channel did not hold");

    chk_pstep_legal:
    assert property (s.cfg.pstep
        |-> s.cfg.src != trig_pkg::SRC_INT && s.cfg.scope == trig_pkg::SCOPE_CHAN)
        else $error("point step in illegal mode");

    chk_fwd_rev:
    assert property ((s.fsm == trig_pkg::ST_FWD) && eng_i.sweep_done && !s.cmd.interleave
        |=> s.cmd.start && s.cmd.reverse ##1 s.fsm == trig_pkg::ST_REV)
        else $error("reverse pass did not follow forward");

    chk_out_pulse:
    assert property (ev && s.cfg.oen && s.ow != '0 && !req_i.wr
        |=> trig_out_o == s.cfg.opol && s.ocnt == $past(s.ow))
        else $error("trigger output pulse wrong");

    cov_full_sweep: cover property ((s.fsm == trig_pkg::ST_REV) && eng_i.sweep_done);
    cov_step_last: cover property ((s.fsm == trig_pkg::ST_STEP) && eng_i.point_done && eng_i.sweep_done);
    cov_ext_delay: cover property ((s.fsm == trig_pkg::ST_DELAY) ##1 s.cmd.start);
    cov_count_hold: cover property (complete && s.chm[1] == trig_pkg::CH_COUNTED
        ##1 s.chm[1] == trig_pkg::CH_HOLD);
endmodule
`default_nettype wire

// *** tb/sweep_engine_model.sv ***
/*
 Sweep engine stand-in: answers pass starts and point steps with
 one-cycle completion pulses after a fixed number of cycles.
 Assumes the controller's commands arrive on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sweep_engine_model #(
    parameter int SWEEP_LEN = 40,
    parameter int POINTS = 3
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire trig_pkg::sweep_cmd_t cmd_i,
    output trig_pkg::sweep_stat_t eng_o
);
    int pass_cnt;
    int step_cnt;
    int pts;
    // SWEEP_LEN sets how slowly a pass completes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pass_cnt <= 0;
            step_cnt <= 0;
            pts <= 0;
            eng_o <= '0;
        end else begin
            eng_o <= '0;
            if (cmd_i.start) pass_cnt <= SWEEP_LEN;
            else if (pass_cnt > 0) pass_cnt <= pass_cnt - 1;
            if (pass_cnt == 1 && !cmd_i.start) eng_o.sweep_done <= 1'b1;
            if (cmd_i.step) step_cnt <= 4;
            else if (step_cnt > 0) step_cnt <= step_cnt - 1;
            if (step_cnt == 1 && !cmd_i.step) begin
                eng_o.point_done <= 1'b1;
                eng_o.sweep_done <= (pts == POINTS - 1);
                pts <= (pts == POINTS - 1) ? 0 : pts + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
 Self-checking bench of the sweep trigger controller.
 Assumes the engine stand-in and the design share one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module testbench;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    trig_pkg::reg_req_t req = '0;
    logic [`DW-1:0] rdata;
    logic [`NIN-1:0] ext = '0;
    trig_pkg::sweep_stat_t eng;
    trig_pkg::sweep_cmd_t cmd;
    trig_pkg::sweep_cmd_t c;
    logic tout;
    logic [31:0] d;
    logic [3:0] mk [4];
    logic [31:0] pc [3] = '{32'h9, 32'hA, 32'hD};
    int errors = 0;
    int samples_checked = 0;
    int starts = 0;
    int lat;
    int s0;
    int n;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (cmd.start === 1'b1) starts++;
    sweep_trigger_controller dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .rdata_o(rdata),
        .ext_trig_i(ext), .eng_i(eng), .cmd_o(cmd), .trig_out_o(tout));
    sweep_engine_model #(.SWEEP_LEN(40), .POINTS(3)) eng_m (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .cmd_i(cmd), .eng_o(eng));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_i);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        d = rdata;
    endtask
    task automatic wait_cmd;
        lat = 0;
        do begin
            @(negedge clk_i);
            lat++;
        end while (cmd.start !== 1'b1 && cmd.step !== 1'b1 && lat < 500);
        c = cmd;
        check(lat < 500, 1'h1);
    endtask
    task automatic wait_idle;
        n = 0;
        do begin
            rd(`A_STAT);
            n++;
        end while (d[10:8] !== 3'h0 && n < 100);
        check(d[10:8], 3'h0);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #1500000;
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        wait_cmd;
        check({c.mask, c.reverse}, {4'hF, 1'h0});
        wait_cmd;
        check({c.mask, c.reverse}, {4'hF, 1'h1});
        wait_cmd;
        check(c.reverse, 1'h0);
        rd(`A_CTRL);
        check(d[2:0], 3'h0);
        rd(`A_OUTW);
        check(d, 32'h1);
        rd(5'h1C);
        check(d, 32'h0);
        // A trigger write acts on the configuration stored before it
        wr(`A_CTRL, 32'h101);
        wait_idle;
        s0 = starts;
        wr(`A_CTRL, 32'h2101);
        wait_cmd;
        check({c.interleave, c.reverse}, 2'h2);
        wait_idle;
        check(starts - s0, 32'h1);
        wr(`A_CTRL, 32'h1);
        wr(`A_CHCNT, 32'h200);
        wr(`A_CHST, 32'hE4);
        mk = '{4'h7, 4'h3, 4'h1, 4'h1};
        for (int i = 0; i < 3; i++) begin
            s0 = starts;
            wr(`A_CTRL, 32'h2001);
            wait_cmd;
            check(c.mask, mk[i]);
            wr(`A_CTRL, 32'h2001);
            wait_idle;
            check(starts - s0, 32'h2);
        end
        rd(`A_STAT);
        check(d[3:0], 4'hE);
        wr(`A_CHST, 32'hC);
        wr(`A_CTRL, 32'h5);
        mk = '{4'h1, 4'h4, 4'h8, 4'h1};
        for (int i = 0; i < 4; i++) begin
            wr(`A_CTRL, 32'h2005);
            wait_cmd;
            check(c.mask, mk[i]);
            wait_idle;
        end
        for (int i = 0; i < 3; i++) begin
            wr(`A_CTRL, pc[i]);
            rd(`A_CTRL);
            check(d[3], i == 2);
        end
        wait_idle;
        mk = '{4'h4, 4'h4, 4'h4, 4'h8};
        for (int i = 0; i < 4; i++) begin
            wr(`A_CTRL, 32'h200D);
            wait_cmd;
            check({c.step, c.mask}, {1'h1, mk[i]});
            wait_idle;
        end
        wr(`A_CHST, 32'h0);
        wr(`A_DELAY, 32'hA);
        for (int q = 0; q < 4; q++) begin
            wr(`A_CTRL, 32'h1);
            wait_idle;
            @(posedge clk_i);
            ext <= {1'b0, q[0], q[0], 1'b0};
            wr(`A_CTRL, 32'h82 | (q << 4));
            s0 = starts;
            @(posedge clk_i);
            ext[1] <= !q[0];
            repeat (30) @(posedge clk_i);
            check(starts - s0, 32'h0);
            ext[2] <= !q[0];
            wait_cmd;
            check({lat > 11 && lat < 23, c.mask}, {1'h1, 4'hF});
            if (q < 2) begin
                wait_cmd;
                wait_cmd;
                check(c.reverse, 1'h0);
            end else begin
                repeat (50) @(posedge clk_i);
            end
            @(posedge clk_i);
            ext[2] <= q[0];
            ext[1] <= q[0];
        end
        wr(`A_CTRL, 32'h1);
        wait_idle;
        wr(`A_OUTW, 32'h5);
        wr(`A_CTRL, 32'h601);
        repeat (2) @(negedge clk_i);
        check(tout, 1'h0);
        wr(`A_CTRL, 32'h2601);
        n = 0;
        repeat (30) begin
            @(negedge clk_i);
            n += tout;
        end
        check(n, 32'h5);
        wait_idle;
        tally_and_finish;
    end
endmodule
`default_nettype wire
